// ### hw/mbw_map.svh
// constants for the modbus write-request handler: function codes, field
// positions, coil codes, frame lengths and checksum settings.
// assumes a byte stream from a modbus rtu framing layer on the same clock.
`ifndef MBW_MAP_SVH
`define MBW_MAP_SVH

// function codes
`define MBW_FN_COIL      8'h05
`define MBW_FN_WREG      8'h06
`define MBW_FN_WDBL      8'h10
// coil data codes
`define MBW_COIL_ON      16'hff00
`define MBW_COIL_OFF     16'h0000
// double-word request fields
`define MBW_DBL_REGS     16'h0002
`define MBW_DBL_BYTES    8'h04
// byte positions inside a frame
`define MBW_POS_SLAVE    0
`define MBW_POS_FN       1
`define MBW_POS_ADDR_HI  2
`define MBW_POS_ADDR_LO  3
`define MBW_POS_DATA_HI  4
`define MBW_POS_DATA_LO  5
`define MBW_POS_BCNT     6
`define MBW_POS_DW0      7
// frame lengths in bytes, checksum included, and the last buffer index
`define MBW_LEN_SHORT    4'd8
`define MBW_LEN_DBL      4'd13
`define MBW_BUF_LAST     4'd12
// reply: six header bytes then two checksum bytes
`define MBW_TX_HDR       3'd6
`define MBW_TX_LAST      3'd7
// checksum
`define MBW_CRC_INIT     16'hffff
`define MBW_CRC_POLY     16'ha001
`define MBW_CRC_GOOD     16'h0000
// parameter address scale
`define MBW_PARAM_SCALE  16'd100

`endif

// ### hw/mbw_pkg.sv
// types for the modbus write-request handler.
// assumes mbw_map.svh supplies the numeric constants.
package mbw_pkg;

    // handler states
    typedef enum logic [1:0] {
        MBW_RX,     // collecting request bytes
        MBW_SKIP,   // unsupported frame, wait for gap
        MBW_CHK,    // judge the frame
        MBW_TX      // send the reply
    } mbw_state_t;

    // registered state of the handler, apart from the two checksum registers
    typedef struct packed {
        mbw_state_t        st;         // current state
        logic [3:0]        cnt;        // bytes received
        logic [12:0][7:0]  buf_b;      // received bytes
        logic [2:0]        idx;        // reply byte on the line
        logic [7:0]        tx_byte;    // reply byte
        logic              tx_valid;   // reply byte offered
        logic              tx_last;    // final reply byte
        logic              coil_wr;    // coil write pulse
        logic              coil_val;   // coil value
        logic              reg_wr;     // register write pulse
        logic              reg_dword;  // write is double word
        logic [31:0]       reg_data;   // register data
        logic [9:0]        grp;        // parameter group
        logic [6:0]        ndx;        // parameter index
    } mbw_regs_t;

endpackage

// ### hw/mbw_crc16.sv
// running modbus crc16 over a byte stream.
// assumes init and update come from logic on the same clock.
`timescale 1ns/10ps
`include "mbw_map.svh"

module mbw_crc16 import mbw_pkg::*; (
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        srst_i,
    // byte stream
    input  wire logic        init_i,   // restart from the start value
    input  wire logic        upd_i,    // fold data_i in
    input  wire logic [7:0]  data_i,
    // result
    output logic      [15:0] crc_o
);

    logic [15:0] crc_q;   // running value
    logic [15:0] crc_d;   // next value

    // one byte, reflected, lsb first
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ `MBW_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    // next value: restart and/or fold
    always_comb begin
        crc_d = init_i ? `MBW_CRC_INIT : crc_q;
        if (upd_i) begin
            crc_d = crc_step(crc_d, data_i);
        end
    end

    // register
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            crc_q <= `MBW_CRC_INIT;
        end else begin
            crc_q <= crc_d;
        end
    end

    assign crc_o = crc_q;

endmodule // mbw_crc16

// ### hw/mbw_handler.sv
// modbus rtu write-request handler: coil force, single register write,
// double-word parameter write; checks and echoes replies.
// assumes a framing layer delivers received bytes and a frame-gap pulse,
// and takes reply bytes with a valid/ready handshake; all on mclk_i.
`timescale 1ns/10ps
`include "mbw_map.svh"

module mbw_handler import mbw_pkg::*; (
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        srst_i,
    // received bytes
    input  wire logic [7:0]  rx_data_i,
    input  wire logic        rx_valid_i,
    input  wire logic        rx_eof_i,      // silent gap ends a frame
    // reply bytes
    output logic      [7:0]  tx_data_o,
    output logic             tx_valid_o,
    output logic             tx_last_o,
    input  wire logic        tx_ready_i,
    // configuration
    input  wire logic [7:0]  dev_addr_i,    // own slave address
    input  wire logic        double_word_order_select_i,  // 0 high word first
    // parameter access check
    output logic      [15:0] acc_addr_o,    // register address under test
    input  wire logic        acc_rw_i,      // parameter is read-write
    input  wire logic        acc_dword_i,   // parameter is double word
    // coil write
    output logic             coil_wr_o,
    output logic      [15:0] coil_addr_o,
    output logic             coil_val_o,
    // register write
    output logic             reg_wr_o,
    output logic             reg_dword_o,
    output logic      [31:0] reg_data_o,
    output logic      [16:0] parameter_group_index_code_o  // {group, index}
);

    mbw_regs_t   r_q;         // registered state
    mbw_regs_t   r_d;         // next state
    logic [15:0] rx_crc;      // checksum of received bytes
    logic [15:0] tx_crc;      // checksum of reply header
    logic        rx_upd;      // received byte folded in
    logic        tx_init;     // reply checksum restart
    logic        tx_upd;      // reply byte folded in
    logic [7:0]  tx_fold;     // reply byte folded in

    // frame length from function code
    function automatic logic [3:0] frame_len(input logic [7:0] fn);
        return (fn == `MBW_FN_WDBL) ? `MBW_LEN_DBL : `MBW_LEN_SHORT;
    endfunction

    // two buffered bytes as a big-endian word
    function automatic logic [15:0] word_at(input logic [12:0][7:0] b, input int p);
        return {b[p], b[p+1]};
    endfunction

    // received bytes feed the checksum while collecting
    assign rx_upd = (r_q.st == MBW_RX) && rx_valid_i && !rx_eof_i && (r_q.cnt <= `MBW_BUF_LAST);

    mbw_crc16 u_rx_crc (
        .mclk_i (mclk_i),
        .srst_i (srst_i),
        .init_i (r_q.cnt == 4'd0),
        .upd_i  (rx_upd),
        .data_i (rx_data_i),
        .crc_o  (rx_crc)
    );

    mbw_crc16 u_tx_crc (
        .mclk_i (mclk_i),
        .srst_i (srst_i),
        .init_i (tx_init),
        .upd_i  (tx_upd),
        .data_i (tx_fold),
        .crc_o  (tx_crc)
    );

    // next-state logic
    always_comb begin
        logic [15:0] w16;
        logic [3:0]  nxt;
        logic [7:0]  fn;
        logic        ok;
        logic [2:0]  ni;
        logic [15:0] ra;
        w16     = word_at(r_q.buf_b, `MBW_POS_DATA_HI);
        ra      = word_at(r_q.buf_b, `MBW_POS_ADDR_HI);
        fn      = r_q.buf_b[`MBW_POS_FN];
        nxt     = r_q.cnt + 4'd1;
        ok      = 1'b0;
        ni      = r_q.idx + 3'd1;
        r_d     = r_q;
        tx_init = 1'b0;
        tx_upd  = 1'b0;
        tx_fold = r_q.buf_b[0];
        // write strobes last one cycle
        r_d.coil_wr = 1'b0;
        r_d.reg_wr  = 1'b0;
        unique case (r_q.st)
            // collect bytes until the length for the function is reached
            MBW_RX: begin
                if (rx_eof_i) begin
                    r_d.cnt = 4'd0;   // gap restarts a frame
                end else if (rx_valid_i) begin
                    r_d.buf_b[r_q.cnt] = rx_data_i;
                    r_d.cnt = nxt;
                    if (r_q.cnt == 4'd1 && rx_data_i != `MBW_FN_COIL && rx_data_i != `MBW_FN_WREG
                        && rx_data_i != `MBW_FN_WDBL) begin
                        r_d.st = MBW_SKIP;
                    end else if (r_q.cnt >= 4'd2 && nxt == frame_len(fn)) begin
                        r_d.st = MBW_CHK;
                    end
                end
            end
            // foreign function: wait for the gap
            MBW_SKIP: begin
                if (rx_eof_i) begin
                    r_d.st  = MBW_RX;
                    r_d.cnt = 4'd0;
                end
            end
            // judge the frame; crc residue over data+crc is zero when good
            MBW_CHK: begin
                r_d.grp = 10'(ra / `MBW_PARAM_SCALE);
                r_d.ndx = 7'(ra % `MBW_PARAM_SCALE);
                if (fn == `MBW_FN_COIL) begin
                    ok = (w16 == `MBW_COIL_ON) || (w16 == `MBW_COIL_OFF);
                end else if (fn == `MBW_FN_WREG) begin
                    ok = acc_rw_i && !acc_dword_i;
                    r_d.reg_dword = 1'b0;
                    r_d.reg_data  = {16'h0000, w16};
                end else begin
                    ok = (w16 == `MBW_DBL_REGS) && (r_q.buf_b[`MBW_POS_BCNT] == `MBW_DBL_BYTES)
                         && acc_rw_i && acc_dword_i;
                    r_d.reg_dword = 1'b1;
                    if (double_word_order_select_i) begin
                        r_d.reg_data = {word_at(r_q.buf_b, `MBW_POS_DW0 + 2),
                                        word_at(r_q.buf_b, `MBW_POS_DW0)};
                    end else begin
                        r_d.reg_data = {word_at(r_q.buf_b, `MBW_POS_DW0),
                                        word_at(r_q.buf_b, `MBW_POS_DW0 + 2)};
                    end
                end
                if (ok && rx_crc == `MBW_CRC_GOOD && r_q.buf_b[`MBW_POS_SLAVE] == dev_addr_i) begin
                    r_d.coil_wr  = (fn == `MBW_FN_COIL);
                    // coil value moves only with an accepted coil write
                    if (fn == `MBW_FN_COIL) begin
                        r_d.coil_val = (w16 == `MBW_COIL_ON);
                    end
                    r_d.reg_wr   = (fn != `MBW_FN_COIL);
                    r_d.st       = MBW_TX;
                    r_d.idx      = 3'd0;
                    r_d.tx_byte  = r_q.buf_b[0];
                    r_d.tx_valid = 1'b1;
                    r_d.tx_last  = 1'b0;
                    tx_init      = 1'b1;
                    tx_upd       = 1'b1;
                end else begin
                    r_d.st  = MBW_RX;
                    r_d.cnt = 4'd0;
                end
            end
            // header bytes from the request, then a fresh checksum
            MBW_TX: begin
                if (tx_ready_i) begin
                    if (r_q.idx == `MBW_TX_LAST) begin
                        r_d.tx_valid = 1'b0;
                        r_d.tx_last  = 1'b0;
                        r_d.st       = MBW_RX;
                        r_d.cnt      = 4'd0;
                    end else begin
                        r_d.idx     = ni;
                        r_d.tx_last = (ni == `MBW_TX_LAST);
                        if (ni < `MBW_TX_HDR) begin
                            r_d.tx_byte = r_q.buf_b[ni];
                            tx_fold     = r_q.buf_b[ni];
                            tx_upd      = 1'b1;
                        end else if (ni == `MBW_TX_HDR) begin
                            r_d.tx_byte = tx_crc[7:0];
                        end else begin
                            r_d.tx_byte = tx_crc[15:8];
                        end
                    end
                end
            end
        endcase
    end

    // state register
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    // outputs straight from state
    assign tx_data_o   = r_q.tx_byte;
    assign tx_valid_o  = r_q.tx_valid;
    assign tx_last_o   = r_q.tx_last;
    assign acc_addr_o  = {r_q.buf_b[`MBW_POS_ADDR_HI], r_q.buf_b[`MBW_POS_ADDR_LO]};
    assign coil_wr_o   = r_q.coil_wr;
    assign coil_addr_o = {r_q.buf_b[`MBW_POS_ADDR_HI], r_q.buf_b[`MBW_POS_ADDR_LO]};
    assign coil_val_o  = r_q.coil_val;
    assign reg_wr_o    = r_q.reg_wr;
    assign reg_dword_o = r_q.reg_dword;
    assign reg_data_o  = r_q.reg_data;
    assign parameter_group_index_code_o = {r_q.grp, r_q.ndx};

endmodule // mbw_handler

// ### test/mbw_handler_asserts.sv
// checker for mbw_handler: write pulses, reply handshake, parameter code.
// assumes it is bound to mbw_handler and sees its ports only.
`timescale 1ns/10ps
module mbw_handler_asserts (
    // clock and reset
    input wire logic        mclk_i,
    input wire logic        srst_i,
    // reply link
    input wire logic [7:0]  tx_data_o,
    input wire logic        tx_valid_o,
    input wire logic        tx_last_o,
    input wire logic        tx_ready_i,
    // config and access
    input wire logic [7:0]  dev_addr_i,
    input wire logic [15:0] acc_addr_o,
    input wire logic        acc_rw_i,
    input wire logic        acc_dword_i,
    // writes
    input wire logic        coil_wr_o,
    input wire logic [15:0] coil_addr_o,
    input wire logic        reg_wr_o,
    input wire logic        reg_dword_o,
    input wire logic [31:0] reg_data_o,
    input wire logic [16:0] parameter_group_index_code_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    wire logic [15:0] grp_w = acc_addr_o / 16'd100;  // expected group
    wire logic [15:0] ndx_w = acc_addr_o % 16'd100;  // expected index
    // last reply byte leaves the link
    sequence s_last_taken;
        tx_valid_o && tx_ready_i && tx_last_o;
    endsequence
    chk_coil_reply: assert property (coil_wr_o |-> tx_valid_o && tx_data_o == dev_addr_i)
        else $error("coil write without reply start");
    chk_reg_reply: assert property (reg_wr_o |-> tx_valid_o && tx_data_o == dev_addr_i)
        else $error("register write without reply start");
    chk_reply_cause: assert property ($rose(tx_valid_o) |-> coil_wr_o || reg_wr_o)
        else $error("reply without accepted write");
    chk_single_upper: assert property (reg_wr_o && !reg_dword_o |-> reg_data_o[31:16] == 16'h0000)
        else $error("single write data upper word not zero");
    chk_param_code: assert property (reg_wr_o |-> parameter_group_index_code_o == {grp_w[9:0], ndx_w[6:0]})
        else $error("parameter code does not match address");
    chk_coil_addr: assert property (coil_wr_o |-> coil_addr_o == acc_addr_o)
        else $error("coil address differs from request");
    chk_rw_gate: assert property (reg_wr_o |-> $past(acc_rw_i) && reg_dword_o == $past(acc_dword_i))
        else $error("write to wrong kind of parameter");
    chk_reply_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
        else $error("reply byte dropped before taken");
    chk_reply_end: assert property (s_last_taken |=> !tx_valid_o)
        else $error("reply continues after last byte");
endmodule // mbw_handler_asserts

bind mbw_handler mbw_handler_asserts u_chk (
    .mclk_i                       (mclk_i),
    .srst_i                       (srst_i),
    .tx_data_o                    (tx_data_o),
    .tx_valid_o                   (tx_valid_o),
    .tx_last_o                    (tx_last_o),
    .tx_ready_i                   (tx_ready_i),
    .dev_addr_i                   (dev_addr_i),
    .acc_addr_o                   (acc_addr_o),
    .acc_rw_i                     (acc_rw_i),
    .acc_dword_i                  (acc_dword_i),
    .coil_wr_o                    (coil_wr_o),
    .coil_addr_o                  (coil_addr_o),
    .reg_wr_o                     (reg_wr_o),
    .reg_dword_o                  (reg_dword_o),
    .reg_data_o                   (reg_data_o),
    .parameter_group_index_code_o (parameter_group_index_code_o)
);

// ### test/mbw_master.sv
// modbus master model: sends request frames with checksum, takes replies.
// assumes mbw_handler on the same clock; stalls tx ready when slow_q set.
`timescale 1ns/10ps
module mbw_master (
    // clock
    input  wire logic       mclk_i,
    // request link
    output logic      [7:0] rx_data_o,
    output logic            rx_valid_o,
    output logic            rx_eof_o,
    // reply link
    input  wire logic [7:0] tx_data_i,
    input  wire logic       tx_valid_i,
    output logic            tx_ready_o
);
    logic       slow_q;     // stall the reply sink
    logic [7:0] rep_q[$];   // reply bytes taken
    initial begin
        rx_data_o = 8'h00;
        rx_valid_o = 1'b0;
        rx_eof_o = 1'b0;
        slow_q = 1'b0;
    end
    // reply sink, toggles ready when slow
    always @(posedge mclk_i) begin
        if (tx_valid_i && tx_ready_o) rep_q.push_back(tx_data_i);
        tx_ready_o <= slow_q ? ~tx_ready_o : 1'b1;
    end
    // checksum over a byte list
    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (b[i]) begin
            c = c ^ {8'h00, b[i]};
            for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction
    // one frame after a gap; bad spoils the checksum
    task automatic send(input logic [7:0] b[$], input logic bad);
        logic [15:0] c;
        c = crc16(b);
        b.push_back(c[7:0] ^ {7'h00, bad});
        b.push_back(c[15:8]);
        @(posedge mclk_i) rx_eof_o <= 1'b1;
        foreach (b[i]) begin
            @(posedge mclk_i);
            rx_eof_o <= 1'b0;
            rx_valid_o <= 1'b1;
            rx_data_o <= b[i];
        end
        @(posedge mclk_i) rx_valid_o <= 1'b0;
        rx_data_o <= ~rx_data_o;  // no stale byte on the line
    endtask
endmodule // mbw_master

// ### test/testbench.sv
// self-checking bench for mbw_handler: coil, register, double-word writes.
// assumes mbw_master drives requests and takes replies.
`timescale 1ns/10ps
module testbench;
    logic        mclk_i = 1'b0;  // 125 MHz clock
    logic        srst_i = 1'b1;  // sync reset
    logic        order_q = 1'b0; // word order
    logic [7:0]  addr_q = 8'h01; // own slave address
    logic        rw_q = 1'b1;    // parameter read-write
    logic        dw_q = 1'b0;    // parameter double word
    logic [7:0]  rx_data, tx_data;
    logic        rx_valid, rx_eof, tx_valid, tx_last, tx_ready;
    logic        coil_wr, coil_val, reg_wr, reg_dword;
    logic [15:0] acc_addr, coil_addr;
    logic [31:0] reg_data;
    logic [16:0] pgi;
    int          n_fail = 0;
    int          n_compared = 0;
    int          n_wr = 0;
    int          n_wr0 = 0;      // write count at transaction start
    always #4 mclk_i = ~mclk_i;
    always @(posedge mclk_i) n_wr <= n_wr + int'(coil_wr | reg_wr);
    mbw_master m (.mclk_i(mclk_i), .rx_data_o(rx_data), .rx_valid_o(rx_valid), .rx_eof_o(rx_eof),
        .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready));
    mbw_handler dut (.mclk_i(mclk_i), .srst_i(srst_i), .rx_data_i(rx_data), .rx_valid_i(rx_valid),
        .rx_eof_i(rx_eof), .tx_data_o(tx_data), .tx_valid_o(tx_valid), .tx_last_o(tx_last),
        .tx_ready_i(tx_ready), .dev_addr_i(addr_q), .double_word_order_select_i(order_q),
        .acc_addr_o(acc_addr), .acc_rw_i(rw_q), .acc_dword_i(dw_q), .coil_wr_o(coil_wr),
        .coil_addr_o(coil_addr), .coil_val_o(coil_val), .reg_wr_o(reg_wr), .reg_dword_o(reg_dword),
        .reg_data_o(reg_data), .parameter_group_index_code_o(pgi));
    task automatic end_sim();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            n_fail++;
            $display("ERROR %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // send a frame, wait bounded for nexp reply bytes
    task automatic xact(input logic [7:0] b[$], input logic bad, input int nexp);
        int t;
        m.rep_q.delete();
        n_wr0 = n_wr;  // counter has a single driver, take a base
        m.send(b, bad);
        for (t = 0; t < 60 && m.rep_q.size() < nexp; t++) @(posedge mclk_i);
        repeat (3) @(posedge mclk_i);
        if (nexp > 0 && t == 60) begin
            n_fail++;
            end_sim();
        end
    endtask
    task automatic cmp_q(input logic [7:0] e[$]);
        check(m.rep_q.size(), e.size());
        foreach (e[i]) check(m.rep_q[i], e[i]);
    endtask
    task automatic none(input logic [7:0] b[$], input logic bad);
        xact(b, bad, 0);
        check(n_wr - n_wr0, 0);
        check(m.rep_q.size(), 0);
    endtask
    task automatic t_coil();
        xact('{8'h01, 8'h05, 8'h00, 8'h01, 8'hff, 8'h00}, 1'b0, 8);
        check(n_wr - n_wr0, 1);
        check(coil_val, 1'b1);
        check(coil_addr, 16'h0001);
        cmp_q('{8'h01, 8'h05, 8'h00, 8'h01, 8'hff, 8'h00, 8'hdd, 8'hfa});
        none('{8'h01, 8'h05, 8'h00, 8'h07, 8'h12, 8'h34}, 1'b0);
        check(coil_val, 1'b1);
        xact('{8'h01, 8'h05, 8'h00, 8'h07, 8'h00, 8'h00}, 1'b0, 8);
        check(coil_val, 1'b0);
        check(coil_addr, 16'h0007);
    endtask
    task automatic t_wreg();
        xact('{8'h01, 8'h06, 8'h00, 8'h02, 8'h0b, 8'hb8}, 1'b0, 8);
        check(reg_data, 32'h00000bb8);
        check(reg_dword, 1'b0);
        cmp_q('{8'h01, 8'h06, 8'h00, 8'h02, 8'h0b, 8'hb8, 8'h2f, 8'h48});
        m.slow_q <= 1'b1;
        xact('{8'h01, 8'h06, 8'h03, 8'h39, 8'h12, 8'h34}, 1'b0, 8);
        m.slow_q <= 1'b0;
        check(pgi, {10'd8, 7'd25});
        check(m.rep_q[5], 8'h34);
    endtask
    task automatic t_wdbl();
        dw_q <= 1'b1;
        xact('{8'h01, 8'h10, 8'h00, 8'h0b, 8'h00, 8'h02, 8'h04, 8'h00, 8'h00, 8'h27, 8'h10}, 1'b0, 8);
        check(reg_data, 32'h00002710);
        check(pgi, {10'd0, 7'd11});
        cmp_q('{8'h01, 8'h10, 8'h00, 8'h0b, 8'h00, 8'h02, 8'h30, 8'h0a});
        order_q <= 1'b1;
        xact('{8'h01, 8'h10, 8'h00, 8'h0b, 8'h00, 8'h02, 8'h04, 8'h00, 8'h00, 8'h27, 8'h10}, 1'b0, 8);
        check(reg_data, 32'h27100000);
        none('{8'h01, 8'h10, 8'h00, 8'h0b, 8'h00, 8'h03, 8'h04, 8'h00, 8'h00, 8'h27, 8'h10}, 1'b0);
        dw_q <= 1'b0;
        none('{8'h01, 8'h10, 8'h00, 8'h0b, 8'h00, 8'h02, 8'h04, 8'h00, 8'h00, 8'h27, 8'h10}, 1'b0);
    endtask
    task automatic t_refuse();
        none('{8'h02, 8'h06, 8'h00, 8'h02, 8'h0b, 8'hb8}, 1'b0);
        none('{8'h01, 8'h06, 8'h00, 8'h02, 8'h0b, 8'hb8}, 1'b1);
        rw_q <= 1'b0;
        none('{8'h01, 8'h06, 8'h00, 8'h02, 8'h0b, 8'hb8}, 1'b0);
        rw_q <= 1'b1;
        // foreign function is skipped, a cut frame is dropped at the next gap
        none('{8'h01, 8'h03, 8'h00, 8'h02, 8'h00, 8'h01}, 1'b0);
        none('{8'h01, 8'h06, 8'h00}, 1'b0);
        addr_q <= 8'h02;
        xact('{8'h02, 8'h06, 8'h00, 8'h02, 8'h0b, 8'hb8}, 1'b0, 8);
        check(m.rep_q[0], 8'h02);
        check(n_wr - n_wr0, 1);
        addr_q <= 8'h01;
    endtask
    initial begin
        repeat (5) @(posedge mclk_i);
        srst_i <= 1'b0;
        t_coil();
        t_wreg();
        t_wdbl();
        t_refuse();
        end_sim();
    end
endmodule // testbench
